// File: sppt_bcd_conv.sv
// Purpose: Converts DIGITS BCD digits (eight by default) into a binary value
// Assumes: Digits are legal BCD; driven from the core clock domain
// Notes:   Purely combinational, so the result is valid in the same cycle
`timescale 1ns/1ns
module sppt_bcd_conv #(
  parameter int DIGITS = 8
) (
  input  wire logic [4*DIGITS-1:0] bcd_i,
  output logic      [4*DIGITS-1:0] bin_o
);
  // Horner accumulation, most significant digit first
  always_comb
  begin
    bin_o = '0;
    for (int i = DIGITS - 1; i >= 0; i--)
    begin
      bin_o = (4*DIGITS)'(bin_o * (4*DIGITS)'(10)) + (4*DIGITS)'(bcd_i[4*i +: 4]);
    end
  end
endmodule

// File: sppt_pkg.sv
// Purpose: Shared constants for the single-phase pulse-train generator
// Assumes: 100 MHz core clock, BCD command operands
// Notes:   Operand codes, limits, count and divider reset values and the clock-derived cycle counts live here
package sppt_pkg;
  // Core clock rate in Hz
  localparam int unsigned CLK_HZ        = 100_000_000;
  // Frequency granularity of one operand unit, in Hz
  localparam int unsigned HZ_PER_UNIT   = 10;
  // Cycles per full period of one frequency unit (10 Hz)
  localparam int unsigned UNIT_CYCLES   = CLK_HZ / HZ_PER_UNIT;
  // Half-period cycles for one unit; divided by the unit count
  localparam logic [31:0] HALF_UNIT_CYC = 32'(UNIT_CYCLES / 2);
  // Output-select operand codes
  localparam logic [11:0] SEL_BIT_A     = 12'h000;
  localparam logic [11:0] SEL_BIT_B     = 12'h010;
  // Mode operand codes
  localparam logic [11:0] MODE_INDEP    = 12'h000;
  localparam logic [11:0] MODE_CONT     = 12'h001;
  // Frequency operand limits (BCD)
  localparam logic [15:0] FREQ_MIN_BCD  = 16'h0002;
  localparam logic [15:0] FREQ_MAX_BCD  = 16'h0200;
  localparam logic [15:0] FREQ_ZERO_BCD = 16'h0000;
  // Halt command control code
  localparam logic [11:0] HALT_CODE     = 12'h003;
  // Count limits (1 up to the 24-bit count maximum)
  localparam logic [23:0] CNT_MIN       = 24'h000001;
  localparam logic [23:0] CNT_MAX       = 24'hffffff;
  // Reset values
  localparam logic [23:0] CNT_RST       = 24'h000000;
  localparam logic [31:0] DIV_RST       = 32'h00000000;
endpackage

// File: sppt_pulse_gen.sv
// Purpose: Single-phase pulse train on one of two step outputs
// Assumes: Commands arrive as one-cycle strobes from same-clock logic
// Notes:   Direction output is out of scope; software drives it elsewhere
`timescale 1ns/1ns
// Notes on behaviour
// [R1] Single-phase train between 20 Hz and 2 kHz
// [R2] Select 000 picks bit a, 010 bit b
// [R3] Mode 000 counted, 001 continuous
// [R4] Counted run stops after preset pulse count
// [R5] Continuous run emits until stopped
// [R6] Count given as two BCD words, low first
// [R7] Load count before starting counted run
// [R8] Frequency operand 0002..0200, 10 Hz per unit
// [R9] Frequency zero halts pulse output
// [R10] At most one output bit pulses
// [R11] Count captured at start, later loads ignored
// [R12] Rate change reuses same select and mode
// [R13] Halt command code 003 stops output
// [R14] Reset leaves both outputs idle
module sppt_pulse_gen (
  input  wire logic        core_clk_i,          // Core clock, 100 MHz
  input  wire logic        srst_i,              // Synchronous reset, active high
  input  wire logic        count_load_command_i, // Strobe: latch count words
  input  wire logic [15:0] count_lo_bcd_i,      // Lower four BCD digits
  input  wire logic [15:0] count_hi_bcd_i,      // Upper four BCD digits
  input  wire logic        start_rate_command_i, // Strobe: start or change rate
  input  wire logic [11:0] out_sel_bcd_i,       // Output-select operand
  input  wire logic [11:0] mode_bcd_i,          // Mode operand
  input  wire logic [15:0] freq_bcd_i,          // Frequency operand
  input  wire logic        halt_command_i,      // Strobe: halt command
  input  wire logic [11:0] halt_code_i,         // Halt control code
  output logic             pulse_out_bit_a_o,   // Step pulses, first bit
  output logic             pulse_out_bit_b_o,   // Step pulses, second bit
  output logic             busy_o,              // Pulses in progress
  output logic             done_o,              // Counted run completed
  output logic             cmd_error_o          // Last start refused: bad operand, or counted start with no count loaded
);

  // Run state, one-hot
  typedef enum logic [1:0] {
    SPPT_IDLE = 2'b01,
    SPPT_RUN  = 2'b10
  } sppt_state_t;

  // Whole module state in one record
  typedef struct packed {
    sppt_state_t st;
    logic        use_b;      // Routed to second bit
    logic        cont;       // Continuous mode
    logic [23:0] loaded;     // Count from last load command
    logic [23:0] remain;     // Pulses still to emit
    logic [31:0] half_cyc;   // Cycles per half period
    logic [31:0] div;        // Half-period counter
    logic        lvl;        // Pulse level
    logic        out_a;
    logic        out_b;
    logic        done;
    logic        err;
  } sppt_reg_t;

  sppt_reg_t   r_q;          // Registered state
  sppt_reg_t   r_d;          // Next state
  logic [31:0] cnt_bin;      // Count words as binary
  logic [15:0] freq_bin;     // Frequency units as binary

  // Count conversion from eight BCD digits
  sppt_bcd_conv #(.DIGITS(8)) u_cnt_conv (   // R6
    .bcd_i ({count_hi_bcd_i, count_lo_bcd_i}),
    .bin_o (cnt_bin)
  );

  // Frequency conversion from four BCD digits
  sppt_bcd_conv #(.DIGITS(4)) u_freq_conv (
    .bcd_i (freq_bcd_i),
    .bin_o (freq_bin)
  );

  // Operand legality, used for both start and rate change
  function automatic logic start_ok(input logic [11:0] sel, input logic [11:0] md,
                                    input logic [15:0] f);
    start_ok = (sel == sppt_pkg::SEL_BIT_A || sel == sppt_pkg::SEL_BIT_B)
             && (md == sppt_pkg::MODE_INDEP || md == sppt_pkg::MODE_CONT)
             && (f >= sppt_pkg::FREQ_MIN_BCD) && (f <= sppt_pkg::FREQ_MAX_BCD);
  endfunction

  // Next-state logic
  always_comb
  begin
    r_d      = r_q;
    r_d.done = r_q.done;
    // Latch the count; the running count is untouched
    if (count_load_command_i)
    begin
      r_d.loaded = cnt_bin[23:0];                               // R11
    end
    // Half-period generator, toggles once per half period
    if (r_q.st == SPPT_RUN)
    begin
      if (r_q.div + 32'h00000001 >= r_q.half_cyc)
      begin
        r_d.div = sppt_pkg::DIV_RST;
        r_d.lvl = ~r_q.lvl;                                     // R1
        // Falling edge ends a pulse
        if (r_q.lvl && !r_q.cont)
        begin
          r_d.remain = r_q.remain - 24'h000001;                // R4
          if (r_q.remain == 24'h000001)
          begin
            r_d.st   = SPPT_IDLE;                               // R4
            r_d.lvl  = 1'b0;
            r_d.done = 1'b1;
          end
        end
      end
      else
      begin
        r_d.div = r_q.div + 32'h00000001;                       // R5
      end
    end
    // Start or rate change command
    if (start_rate_command_i)
    begin
      if (freq_bcd_i == sppt_pkg::FREQ_ZERO_BCD)
      begin
        r_d.st  = SPPT_IDLE;                                    // R9
        r_d.lvl = 1'b0;
        r_d.err = 1'b0;
      end
      else if (!start_ok(out_sel_bcd_i, mode_bcd_i, freq_bcd_i))
      begin
        r_d.err = 1'b1;                                         // R8
      end
      else if (r_q.st == SPPT_RUN)
      begin
        // Rate change keeps route, mode and count
        r_d.half_cyc = sppt_pkg::HALF_UNIT_CYC / 32'(freq_bin); // R12
        r_d.err      = 1'b0;
      end
      else if (mode_bcd_i == sppt_pkg::MODE_INDEP && r_q.loaded == sppt_pkg::CNT_RST)
      begin
        r_d.err = 1'b1;                                         // R7
      end
      else
      begin
        r_d.st       = SPPT_RUN;
        r_d.use_b    = (out_sel_bcd_i == sppt_pkg::SEL_BIT_B);  // R2
        r_d.cont     = (mode_bcd_i == sppt_pkg::MODE_CONT);     // R3
        r_d.remain   = r_q.loaded;                              // R11
        r_d.half_cyc = sppt_pkg::HALF_UNIT_CYC / 32'(freq_bin); // R8
        r_d.div      = sppt_pkg::DIV_RST;
        r_d.lvl      = 1'b1;
        r_d.done     = 1'b0;
        r_d.err      = 1'b0;
      end
    end
    // Halt command wins over a start or the generator for state and level
    if (halt_command_i && halt_code_i == sppt_pkg::HALT_CODE)
    begin
      r_d.st  = SPPT_IDLE;                                      // R13
      r_d.lvl = 1'b0;
    end
    // Route the level to exactly one bit
    r_d.out_a = (r_d.st == SPPT_RUN) && r_d.lvl && !r_d.use_b;  // R10
    r_d.out_b = (r_d.st == SPPT_RUN) && r_d.lvl && r_d.use_b;   // R10
  end

  // State register
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      r_q.st       <= SPPT_IDLE;                                // R14
      r_q.use_b    <= 1'b0;
      r_q.cont     <= 1'b0;
      r_q.loaded   <= sppt_pkg::CNT_RST;
      r_q.remain   <= sppt_pkg::CNT_RST;
      r_q.half_cyc <= sppt_pkg::DIV_RST;
      r_q.div      <= sppt_pkg::DIV_RST;
      r_q.lvl      <= 1'b0;
      r_q.out_a    <= 1'b0;
      r_q.out_b    <= 1'b0;
      r_q.done     <= 1'b0;
      r_q.err      <= 1'b0;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // Outputs straight from flip-flops
  assign pulse_out_bit_a_o = r_q.out_a;
  assign pulse_out_bit_b_o = r_q.out_b;
  assign busy_o            = r_q.st[1];   // One-hot run bit, no decode after the flop
  assign done_o            = r_q.done;
  assign cmd_error_o       = r_q.err;

  // Assertions
  property p_one_bit;
    @(posedge core_clk_i) disable iff (srst_i) !(pulse_out_bit_a_o && pulse_out_bit_b_o);
  endproperty
  a_one_bit: assert property (p_one_bit) else $error("both outputs high"); // R10

  property p_halt;
    @(posedge core_clk_i) disable iff (srst_i)
      halt_command_i && halt_code_i == sppt_pkg::HALT_CODE |=> !busy_o;
  endproperty
  a_halt: assert property (p_halt) else $error("halt did not stop"); // R13

  property p_zero;
    @(posedge core_clk_i) disable iff (srst_i)
      start_rate_command_i && freq_bcd_i == 16'h0000 |=> !busy_o && !pulse_out_bit_a_o;
  endproperty
  a_zero: assert property (p_zero) else $error("zero rate kept running"); // R9

  property p_reset;
    @(posedge core_clk_i) srst_i |=> !pulse_out_bit_a_o && !pulse_out_bit_b_o && !busy_o;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs active after reset"); // R14

  property p_idle_quiet;
    @(posedge core_clk_i) disable iff (srst_i)
      !busy_o |-> !pulse_out_bit_a_o && !pulse_out_bit_b_o;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("pulse while idle"); // R1

  property p_route_b;
    @(posedge core_clk_i) disable iff (srst_i)
      !busy_o && start_rate_command_i && !halt_command_i
      && start_ok(out_sel_bcd_i, mode_bcd_i, freq_bcd_i)
      && mode_bcd_i == sppt_pkg::MODE_CONT && out_sel_bcd_i == sppt_pkg::SEL_BIT_B
      |=> pulse_out_bit_b_o && busy_o;
  endproperty
  a_route_b: assert property (p_route_b) else $error("bit b not started"); // R2

  property p_cont_runs;
    @(posedge core_clk_i) disable iff (srst_i)
      busy_o && r_q.cont && !start_rate_command_i && !halt_command_i |=> busy_o;
  endproperty
  a_cont_runs: assert property (p_cont_runs) else $error("continuous run stopped"); // R5

  property p_count_hold;
    @(posedge core_clk_i) disable iff (srst_i)
      busy_o && count_load_command_i && !(r_q.lvl && r_q.div + 32'h1 >= r_q.half_cyc)
      |=> $stable(r_q.remain);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("load altered count"); // R11

  property p_done;
    @(posedge core_clk_i) disable iff (srst_i) $rose(done_o) |-> !busy_o && !r_q.cont;
  endproperty
  a_done: assert property (p_done) else $error("done while busy"); // R4

  c_start_a: cover property (@(posedge core_clk_i) $rose(pulse_out_bit_a_o));
  c_start_b: cover property (@(posedge core_clk_i) $rose(pulse_out_bit_b_o));
  c_done:    cover property (@(posedge core_clk_i) $rose(done_o));
  c_halt:    cover property (@(posedge core_clk_i) busy_o && halt_command_i);
endmodule

// File: sppt_pulse_gen_tb_top.sv
// Purpose: Self-checking bench for the single-phase pulse-train generator
// Assumes: One 100 MHz clock; inputs change on the falling edge
// Notes:   One 2 kHz pulse period takes 50k cycles, so runs are kept short
`timescale 1ns/1ns
module sppt_pulse_gen_tb_top;
  logic        core_clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        load_s = 1'b0;  // Count-load strobe
  logic [15:0] cnt_lo = 16'h0; // Count low digits
  logic [15:0] cnt_hi = 16'h0; // Count high digits
  logic        start_s = 1'b0; // Start strobe
  logic [11:0] sel = 12'h0;    // Output select
  logic [11:0] mode = 12'h0;   // Mode operand
  logic [15:0] freq = 16'h0;   // Frequency operand
  logic        halt_s = 1'b0;  // Halt strobe
  logic [11:0] hcode = 12'h0;  // Halt code
  logic        pa, pb, busy, done, cerr;
  logic [31:0] ea, eb, hl;
  int          err_count = 0;
  int          checks_done = 0;
  // Half period at 2 kHz: 200 units
  localparam logic [31:0] HALF200 = sppt_pkg::HALF_UNIT_CYC / 32'd200;

  sppt_pulse_gen DUT (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .count_load_command_i(load_s), .count_lo_bcd_i(cnt_lo), .count_hi_bcd_i(cnt_hi),
    .start_rate_command_i(start_s), .out_sel_bcd_i(sel), .mode_bcd_i(mode),
    .freq_bcd_i(freq), .halt_command_i(halt_s), .halt_code_i(hcode),
    .pulse_out_bit_a_o(pa), .pulse_out_bit_b_o(pb), .busy_o(busy), .done_o(done),
    .cmd_error_o(cerr));
  sppt_step_rx RX (.core_clk_i(core_clk_i), .srst_i(srst_i), .step_a_i(pa),
    .step_b_i(pb), .edges_a_o(ea), .edges_b_o(eb), .high_len_o(hl));

  // Free-running clock, 10 ns period
  initial
  begin
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    if (err_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // One-cycle strobes, launched and dropped on falling edges
  task automatic load(input logic [15:0] hi, input logic [15:0] lo);
    @(negedge core_clk_i) {load_s, cnt_hi, cnt_lo} = {1'b1, hi, lo};
    @(negedge core_clk_i) load_s = 1'b0;
  endtask
  task automatic start(input logic [11:0] s, input logic [11:0] m, input logic [15:0] f);
    @(negedge core_clk_i) {start_s, sel, mode, freq} = {1'b1, s, m, f};
    @(negedge core_clk_i) start_s = 1'b0;
  endtask
  task automatic halt(input logic [11:0] c);
    @(negedge core_clk_i) {halt_s, hcode} = {1'b1, c};
    @(negedge core_clk_i) halt_s = 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  // Outputs idle after reset and with no command
  task automatic t_reset();
    cyc(50);
    chk("idle outputs", 32'h0, {27'h0, pa, pb, busy, done, cerr});
    chk("no steps", 32'h0, ea | eb);
  endtask

  // Illegal operands, and counted start before any count load, are refused
  // A zero-rate stop clears the error first, so a sticky flag cannot hide a miss
  task automatic t_refuse();
    logic [11:0] s [5] = '{12'h000, 12'h001, 12'h000, 12'h000, 12'h000};
    logic [11:0] m [5] = '{12'h000, 12'h001, 12'h002, 12'h001, 12'h001};
    logic [15:0] f [5] = '{16'h0200, 16'h0200, 16'h0200, 16'h0201, 16'h0001};
    for (int i = 0; i < 5; i++)
    begin
      start(12'h000, 12'h001, sppt_pkg::FREQ_ZERO_BCD);
      chk("error cleared by stop", 32'h0, {31'h0, cerr});
      start(s[i], m[i], f[i]);
      cyc(1);
      chk("refused error", 32'h1, {31'h0, cerr});
      chk("refused busy", 32'h0, {30'h0, busy, pa | pb});
    end
  endtask

  // Continuous run on second bit; wrong halt code ignored, code 003 stops it
  task automatic t_cont_halt();
    start(sppt_pkg::SEL_BIT_B, sppt_pkg::MODE_CONT, 16'h0200);
    chk("b start", 32'h6, {29'h0, busy, pb, pa});
    chk("error cleared", 32'h0, {31'h0, cerr});
    halt(12'h000);
    chk("bad halt ignored", 32'h6, {29'h0, busy, pb, pa});
    halt(sppt_pkg::HALT_CODE);
    cyc(1);
    chk("halted", 32'h0, {30'h0, busy, pb});
  endtask

  // Zero frequency stops a continuous run on the first bit
  task automatic t_zero();
    start(sppt_pkg::SEL_BIT_A, sppt_pkg::MODE_CONT, 16'h0200);
    chk("a start", 32'h5, {29'h0, busy, pb, pa});
    start(sppt_pkg::SEL_BIT_A, sppt_pkg::MODE_CONT, sppt_pkg::FREQ_ZERO_BCD);
    cyc(1);
    chk("zero stop", 32'h0, {29'h0, busy, pa, cerr});
  endtask

  // Counted run of one pulse; a load during the run must not extend it
  // Starts at 1 kHz and is raised to 2 kHz at once, so the high phase shows the new rate
  task automatic t_counted();
    int n;
    logic [31:0] e0;
    e0 = ea;
    load(16'h0000, 16'h0001);
    start(sppt_pkg::SEL_BIT_A, sppt_pkg::MODE_INDEP, 16'h0100);
    chk("counted start", 32'h1, {31'h0, busy});
    load(16'h0000, 16'h0005);
    start(sppt_pkg::SEL_BIT_A, sppt_pkg::MODE_INDEP, 16'h0200);
    chk("rate change", 32'h2, {30'h0, busy, cerr});
    n = 0;
    while (busy === 1'b1 && n < 60000)
    begin
      cyc(1);
      n++;
    end
    cyc(3);
    chk("one pulse", e0 + 32'h1, ea);
    chk("no b pulses", 32'h1, eb);
    chk("high length", HALF200, hl);
    chk("done flag", 32'h2, {30'h0, done, busy});
  endtask

  // Watchdog reckoned from the counted run plus margin
  // All scenarios together take about 25k cycles; 80k leaves room for a slow path
  initial
  begin
    #(80000 * 10);
    err_count++;
    tally_and_finish();
  end

  // Main sequence: 10-cycle reset then scenarios
  initial
  begin
    cyc(10);
    srst_i = 1'b0;
    t_reset();
    t_refuse();
    t_cont_halt();
    t_zero();
    t_counted();
    tally_and_finish();
  end
endmodule

// File: sppt_step_rx.sv
// Purpose: Behavioural motor driver that counts step pulses on both inputs
// Assumes: Step inputs are registered outputs of the pulse generator
// Notes:   Receive only; it drives nothing back towards the generator
`timescale 1ns/1ns
module sppt_step_rx (
  input  wire logic        core_clk_i, // Core clock
  input  wire logic        srst_i,     // Synchronous reset, active high
  input  wire logic        step_a_i,   // Step input, first bit
  input  wire logic        step_b_i,   // Step input, second bit
  output logic      [31:0] edges_a_o,  // Rising edges seen on first bit
  output logic      [31:0] edges_b_o,  // Rising edges seen on second bit
  output logic      [31:0] high_len_o  // Length of last high phase
);
  logic        a_q;   // Previous first bit
  logic        b_q;   // Previous second bit
  logic [31:0] run_q; // Cycles since last rising edge

  // Edge counting and high-phase timing, as a driver's step input would see it
  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      {a_q, b_q} <= 2'h0;
      {edges_a_o, edges_b_o, high_len_o, run_q} <= '0;
    end
    else
    begin
      a_q   <= step_a_i;
      b_q   <= step_b_i;
      run_q <= ((step_a_i & ~a_q) | (step_b_i & ~b_q)) ? 32'h1 : run_q + 32'h1;
      if (step_a_i & ~a_q)
        edges_a_o <= edges_a_o + 32'h1;
      if (step_b_i & ~b_q)
        edges_b_o <= edges_b_o + 32'h1;
      // Falling edge closes the high phase
      if ((a_q & ~step_a_i) | (b_q & ~step_b_i))
        high_len_o <= run_q;
    end
  end
endmodule
